// >>> flash_cycle_gen.sv
// Purpose: Performs one strobed write or read cycle on the flash pins
// Assumes: Start pulse only while idle; strobes active low
// Notes:   Address and data held over the whole strobe
`timescale 1ns/1ps
module flash_cycle_gen
   import flash_host_pkg::*;
#(
   parameter int HOLD_CYCLES = STROBE_CYCLES
) (
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        start_i,
   input  wire logic        write_i,
   input  wire logic [21:0] addr_i,
   input  wire logic [15:0] data_i,
   input  wire logic [15:0] dq_in_i,
   output logic             done_o,
   output logic [15:0]      rdata_o,
   output logic [21:0]      flash_addr_o,
   output logic [15:0]      dq_out_o,
   output logic             dq_oe_o,
   output logic             chip_sel_n_o,
   output logic             write_n_o,
   output logic             out_en_n_o
);
   initial begin
      if (HOLD_CYCLES < 1 || HOLD_CYCLES > 253) $error("HOLD_CYCLES out of range");
   end

   typedef enum logic [2:0] {
      CY_IDLE  = 3'b001,
      CY_SETUP = 3'b010,
      CY_PULSE = 3'b100
   } cycle_state_t;

   cycle_state_t state_q, state_d;
   logic [7:0]   cnt_q, cnt_d;
   logic         wr_q, wr_d;
   logic         done_q, done_d;
   logic [15:0]  rdata_q, rdata_d;
   logic [21:0]  addr_q, addr_d;
   logic [15:0]  dout_q, dout_d;
   logic         cs_q, cs_d, we_q, we_d, oe_q, oe_d, dqoe_q, dqoe_d;

   // Cycle sequencing: address set up before strobe, data held past it
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      wr_d    = wr_q;
      done_d  = 1'b0;
      rdata_d = rdata_q;
      addr_d  = addr_q;
      dout_d  = dout_q;
      cs_d    = cs_q;
      we_d    = we_q;
      oe_d    = oe_q;
      dqoe_d  = dqoe_q;
      unique case (state_q)
         CY_IDLE: begin
            dqoe_d = 1'b0;              // Released one cycle after strobes rise
            if (start_i) begin
               addr_d  = addr_i;        // Stable before later falling strobe
               dout_d  = data_i;
               wr_d    = write_i;
               dqoe_d  = write_i;
               state_d = CY_SETUP;
            end
         end
         CY_SETUP: begin
            cs_d    = 1'b0;
            we_d    = ~wr_q;
            oe_d    = wr_q;
            cnt_d   = 8'(HOLD_CYCLES) + (wr_q ? 8'h00 : 8'h02);  // Reads wait out the pin synchroniser
            state_d = CY_PULSE;
         end
         CY_PULSE: begin
            if (cnt_q > 8'h01) begin
               cnt_d = cnt_q - 8'h01;
            end else begin
               rdata_d = dq_in_i;      // Pins already two-stage synced
               cs_d    = 1'b1;         // Data still driven at rising edge
               we_d    = 1'b1;
               oe_d    = 1'b1;
               done_d  = 1'b1;
               state_d = CY_IDLE;
            end
         end
         default: state_d = CY_IDLE;
      endcase
   end

   // Registers
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state_q <= CY_IDLE;
         cnt_q   <= 8'h00;
         wr_q    <= 1'b0;
         done_q  <= 1'b0;
         rdata_q <= 16'h0000;
         addr_q  <= 22'h000000;
         dout_q  <= 16'h0000;
         cs_q    <= 1'b1;
         we_q    <= 1'b1;
         oe_q    <= 1'b1;
         dqoe_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         wr_q    <= wr_d;
         done_q  <= done_d;
         rdata_q <= rdata_d;
         addr_q  <= addr_d;
         dout_q  <= dout_d;
         cs_q    <= cs_d;
         we_q    <= we_d;
         oe_q    <= oe_d;
         dqoe_q  <= dqoe_d;
      end
   end

   assign done_o       = done_q;
   assign rdata_o      = rdata_q;
   assign flash_addr_o = addr_q;
   assign dq_out_o     = dout_q;
   assign dq_oe_o      = dqoe_q;
   assign chip_sel_n_o = cs_q;
   assign write_n_o    = we_q;
   assign out_en_n_o   = oe_q;

   // Write strobe never low without chip select
   property p_we_with_cs;
      @(posedge clk_i) disable iff (sys_rst_i) !write_n_o |-> !chip_sel_n_o;
   endproperty
   a_we_with_cs: assert property (p_we_with_cs) else $error("write strobe without chip select");

endmodule // flash_cycle_gen

// >>> flash_dev_model.sv
// Purpose: Behavioural flash device facing the host controller
// Assumes: Word addresses, active low strobes
// Notes:   Short algorithm times; a 1 over a 0 sets the timing flag
`timescale 1ns/1ps
module flash_dev_model #(
   parameter int          PROG_T  = 200,
   parameter int          ERASE_T = 400,
   parameter logic [15:0] MFR_ID  = 16'h00A5  // Arbitrary value
) (
   input  wire logic        clk_i,
   input  wire logic [21:0] addr_i,
   input  wire logic [15:0] dq_i,
   input  wire logic        cs_n_i,
   input  wire logic        we_n_i,
   input  wire logic        oe_n_i,
   input  wire logic        word_i,
   output logic [15:0]      q_o
);
   logic [15:0] mem [int];
   logic [21:0] la, pa, ba;
   logic [15:0] pd, rd, last = 16'h0000;
   logic [7:0]  d;
   logic [2:0]  sq = 3'h0;
   int          n = 0;
   logic        ps = 1'h0, pb = 1'h0, eb = 1'h0, ch = 1'h0, su = 1'h0, lim = 1'h0, au = 1'h0, tg = 1'h0;
   wire         wr_n = cs_n_i | we_n_i;
   wire         rd_n = cs_n_i | oe_n_i;
   wire         run  = (pb && !lim) || (eb && !su);
   wire         a555 = la == 22'h000555;
   // Erased cells read as ones
   function automatic logic [15:0] arr(input logic [21:0] a);
      return mem.exists(a) ? mem[a] : 16'hFFFF;
   endfunction
   // Status, identity or array; a released bus shows the inverse
   always @* begin
      if ((pb || eb) && !(su && addr_i[20:12] != ba[20:12]))
         rd = {8'h00, pb & ~pd[7], tg, lim, 5'h00};
      else
         rd = au ? ((addr_i == 22'h0) ? MFR_ID : 16'h0000) : arr(addr_i);
   end
   assign q_o = rd_n ? ~last : rd;
   always @(posedge rd_n) begin
      last = rd;
      tg   = tg ^ (pb | eb);
   end
   always @(negedge wr_n) la = addr_i;
   // Command decoder at the earlier rising strobe
   always @(posedge wr_n) begin
      d = dq_i[7:0];
      if (run)
         su = su | (eb && !ch && d == 8'hB0);
      else if (d == 8'hF0)
         {sq, ps, au, lim, pb} = '0;
      else if (ps)
         {pa, pd, ps, pb, n} = {la, word_i ? dq_i : {8'hFF, d}, 2'h1, 32'h0};
      else if (su && sq == 3'h0 && d == 8'h30)
         su = 1'h0;
      else case (sq)
         3'h0, 3'h3: sq = (a555 && d == 8'hAA) ? sq + 3'h1 : 3'h0;
         3'h1, 3'h4: sq = (la == 22'h0002AA && d == 8'h55) ? sq + 3'h1 : 3'h0;
         3'h2: begin
            sq = (a555 && d == 8'h80 && !su) ? 3'h3 : 3'h0;
            au = au | (a555 && d == 8'h90 && !su);
            ps = a555 && d == 8'hA0;
         end
         default: begin
            {sq, ch, ba, n} = {3'h0, a555 && d == 8'h10, la, 32'h0};
            eb = ch || d == 8'h30;
         end
      endcase
   end
   // Internal program and erase timing
   always @(posedge clk_i) begin
      n = run ? n + 1 : n;
      if (pb && !lim && n == PROG_T) begin
         lim = |(pd & ~arr(pa));
         if (!lim)
            mem[pa] = pd;
         pb = lim;
      end
      if (eb && !su && n == ERASE_T) begin
         foreach (mem[k])
            if (ch || k[20:12] == ba[20:12])
               mem[k] = 16'hFFFF;
         eb = 1'h0;
      end
   end
endmodule  // flash_dev_model

// >>> flash_host_ctrl.sv
// Purpose: Host controller that issues flash command sequences
// Assumes: Software orders operations over Avalon-MM registers
// Notes:   Word mode; device keeps its own command state
//
// The implementer's own choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
// Operation
// - Timing limit flag: host writes reset
// - Autoselect exits only by reset
// - Autoselect: two unlocks then command
// - Program: four writes, device times itself
// - Timing limit bit high; host resets
// - Chip erase: six writes, ignores commands
// - Sector erase six writes; sector bits
// - Only suspend accepted during sector erase
// - Resume continues erase; suspend allowed again
module flash_host_ctrl
   import flash_host_pkg::*;
#(
   parameter int SUSPEND_WAIT = SUSPEND_CYCLES
) (
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic [3:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   output logic [31:0]      avs_readdata_o,
   output logic             avs_waitrequest_o,
   input  wire logic [15:0] dq_i,
   output logic [15:0]      dq_o,
   output logic             dq_oe_o,
   output logic [21:0]      flash_addr_o,
   output logic             chip_sel_n_o,
   output logic             write_n_o,
   output logic             out_en_n_o,
   output logic             word_mode_o
);
   initial begin
      if (SUSPEND_WAIT < 8 || SUSPEND_WAIT > 65535) $error("SUSPEND_WAIT out of range");
   end

   // ------------------------------------------------------------
   // State and storage
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      H_IDLE  = 4'b0001,
      H_ISSUE = 4'b0010,
      H_WAIT  = 4'b0100,
      H_SUSP  = 4'b1000
   } host_state_t;

   host_state_t state_q, state_d;
   logic [3:0]  op_q, op_d;
   logic [3:0]  step_q, step_d;
   logic [15:0] susp_cnt_q, susp_cnt_d;
   logic [21:0] addr_reg_q, addr_reg_d;
   logic [15:0] wdata_q, wdata_d;
   logic [15:0] rdata_q, rdata_d;
   logic        word_q, word_d;
   logic        wait_q, wait_d;
   logic [31:0] bus_rd_q, bus_rd_d;
   logic [15:0] dq_meta_q, dq_sync_q;
   logic        cyc_start, cyc_write, cyc_done;
   logic [21:0] cyc_addr;
   logic [15:0] cyc_data, cyc_rdata;

   // Sequence length of each operation
   function automatic logic [3:0] seq_len(input logic [3:0] op);
      unique case (op)
         OP_PROGRAM:      seq_len = 4'h4;
         OP_CHIP_ERASE,
         OP_SECTOR_ERASE: seq_len = 4'h6;
         OP_AUTOSELECT:   seq_len = 4'h3;
         default:         seq_len = 4'h1;
      endcase
   endfunction

   // Address and data of one bus cycle of a sequence
   function automatic logic [37:0] seq_cycle(input logic [3:0] op, input logic [3:0] step,
                                             input logic [21:0] a, input logic [15:0] d);
      logic [21:0] sa;
      sa = 22'h000000;
      sa[SECTOR_MSB:SECTOR_LSB] = a[SECTOR_MSB:SECTOR_LSB];
      seq_cycle = {UNLOCK_ADDR_1, 8'h00, UNLOCK_DATA_1};
      if (op == OP_READ) begin
         seq_cycle = {a, d};
      end else if (op == OP_RESET || op == OP_SUSPEND || op == OP_RESUME) begin
         // Address is don't care for single-write commands
         seq_cycle = {22'h000000, 8'h00,
                      (op == OP_RESET) ? CMD_RESET :
                      (op == OP_SUSPEND) ? CMD_SUSPEND : CMD_RESUME};
      end else begin
         unique case (step)
            4'h0, 4'h3: seq_cycle = {UNLOCK_ADDR_1, 8'h00, UNLOCK_DATA_1};
            4'h1, 4'h4: seq_cycle = {UNLOCK_ADDR_2, 8'h00, UNLOCK_DATA_2};
            4'h2: seq_cycle = {UNLOCK_ADDR_1, 8'h00,
                               (op == OP_PROGRAM) ? CMD_PROGRAM :
                               (op == OP_AUTOSELECT) ? CMD_AUTOSELECT : CMD_ERASE_SETUP};
            default: begin
               if (op == OP_PROGRAM)
                  seq_cycle = {a, d};
               else if (op == OP_CHIP_ERASE)
                  seq_cycle = {UNLOCK_ADDR_1, 8'h00, CMD_CHIP_ERASE};
               else
                  seq_cycle = {sa, 8'h00, CMD_SECTOR_ERASE};
            end
         endcase
         if (op == OP_PROGRAM && step == 4'h3) seq_cycle = {a, d};
      end
   endfunction

   // ------------------------------------------------------------
   // Pin input synchroniser
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         dq_meta_q <= 16'h0000;
         dq_sync_q <= 16'h0000;
      end else begin
         dq_meta_q <= dq_i;
         dq_sync_q <= dq_meta_q;
      end
   end

   // ------------------------------------------------------------
   // Bus cycle engine
   // ------------------------------------------------------------
   flash_cycle_gen #(.HOLD_CYCLES(STROBE_CYCLES)) u_cycle (
      .clk_i        (clk_i),
      .sys_rst_i    (sys_rst_i),
      .start_i      (cyc_start),
      .write_i      (cyc_write),
      .addr_i       (cyc_addr),
      .data_i       (cyc_data),
      .dq_in_i      (dq_sync_q),
      .done_o       (cyc_done),
      .rdata_o      (cyc_rdata),
      .flash_addr_o (flash_addr_o),
      .dq_out_o     (dq_o),
      .dq_oe_o      (dq_oe_o),
      .chip_sel_n_o (chip_sel_n_o),
      .write_n_o    (write_n_o),
      .out_en_n_o   (out_en_n_o)
   );

   assign cyc_start = (state_q == H_ISSUE);
   assign cyc_write = (op_q != OP_READ);
   assign {cyc_addr, cyc_data} = seq_cycle(op_q, step_q, addr_reg_q, wdata_q);

   // ------------------------------------------------------------
   // Sequencer and register slave
   // ------------------------------------------------------------
   always_comb begin
      state_d    = state_q;
      op_d       = op_q;
      step_d     = step_q;
      susp_cnt_d = susp_cnt_q;
      addr_reg_d = addr_reg_q;
      wdata_d    = wdata_q;
      rdata_d    = rdata_q;
      word_d     = word_q;
      wait_d     = 1'b1;
      bus_rd_d   = bus_rd_q;
      // Registers accept access only when sequencer is idle
      if ((avs_read_i || avs_write_i) && wait_q && state_q == H_IDLE) begin
         wait_d = 1'b0;
         if (avs_write_i) begin
            unique case (avs_address_i)
               REG_CTRL: begin
                  op_d    = avs_writedata_i[3:0];
                  word_d  = avs_writedata_i[8];
                  step_d  = SEQ_RESET;
                  state_d = H_ISSUE;
               end
               REG_ADDR:  addr_reg_d = avs_writedata_i[21:0];
               REG_WDATA: wdata_d    = avs_writedata_i[15:0];
               default: ;
            endcase
         end else begin
            unique case (avs_address_i)
               REG_CTRL:   bus_rd_d = {23'h000000, word_q, 4'h0, op_q};
               REG_ADDR:   bus_rd_d = {10'h000, addr_reg_q};
               REG_WDATA:  bus_rd_d = {16'h0000, wdata_q};
               REG_STATUS: bus_rd_d = {13'h0000, rdata_q[TIMING_LIMIT_FLAG_BIT],
                                       rdata_q[TOGGLE_STATUS_BIT], rdata_q[POLLING_STATUS_BIT],
                                       rdata_q};
               default:    bus_rd_d = 32'h00000000;
            endcase
         end
      end
      unique case (state_q)
         H_IDLE: ;
         H_ISSUE: state_d = H_WAIT;
         H_WAIT: begin
            if (cyc_done) begin
               if (op_q == OP_READ) rdata_d = cyc_rdata;
               if (step_q + 4'h1 < seq_len(op_q)) begin
                  step_d  = step_q + 4'h1;
                  state_d = H_ISSUE;
               end else if (op_q == OP_SUSPEND) begin
                  susp_cnt_d = 16'(SUSPEND_WAIT);
                  state_d    = H_SUSP;
               end else begin
                  state_d = H_IDLE;
               end
            end
         end
         H_SUSP: begin
            // Hold off until erase has surely halted
            if (susp_cnt_q > 16'h0001) susp_cnt_d = susp_cnt_q - 16'h0001;
            else state_d = H_IDLE;
         end
         default: state_d = H_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state_q    <= H_IDLE;
         op_q       <= OP_READ;
         step_q     <= SEQ_RESET;
         susp_cnt_q <= 16'h0000;
         addr_reg_q <= 22'h000000;
         wdata_q    <= 16'h0000;
         rdata_q    <= 16'h0000;
         word_q     <= 1'b1;
         wait_q     <= 1'b1;
         bus_rd_q   <= 32'h00000000;
      end else begin
         state_q    <= state_d;
         op_q       <= op_d;
         step_q     <= step_d;
         susp_cnt_q <= susp_cnt_d;
         addr_reg_q <= addr_reg_d;
         wdata_q    <= wdata_d;
         rdata_q    <= rdata_d;
         word_q     <= word_d;
         wait_q     <= wait_d;
         bus_rd_q   <= bus_rd_d;
      end
   end

   assign avs_readdata_o    = bus_rd_q;
   assign avs_waitrequest_o = wait_q;
   assign word_mode_o       = word_q;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_reset_cmd;
      @(posedge clk_i) disable iff (sys_rst_i)
         (state_q == H_ISSUE && op_q == OP_RESET) |-> cyc_data == {8'h00, CMD_RESET};
   endproperty
   a_reset_cmd: assert property (p_reset_cmd) else $error("reset command byte wrong");

   property p_autoselect_cmd;
      @(posedge clk_i) disable iff (sys_rst_i)
         (state_q == H_ISSUE && op_q == OP_AUTOSELECT && step_q == 4'h2)
            |-> cyc_data[7:0] == CMD_AUTOSELECT && cyc_addr == UNLOCK_ADDR_1;
   endproperty
   a_autoselect_cmd: assert property (p_autoselect_cmd) else $error("autoselect cycle wrong");

   property p_program_last;
      @(posedge clk_i) disable iff (sys_rst_i)
         (state_q == H_ISSUE && op_q == OP_PROGRAM && step_q == 4'h3)
            |-> cyc_addr == addr_reg_q && cyc_data == wdata_q;
   endproperty
   a_program_last: assert property (p_program_last) else $error("program data cycle wrong");

   property p_unlock_first;
      @(posedge clk_i) disable iff (sys_rst_i)
         (state_q == H_ISSUE && step_q == 4'h0 && seq_len(op_q) > 4'h1)
            |-> cyc_addr == UNLOCK_ADDR_1 && cyc_data[7:0] == UNLOCK_DATA_1;
   endproperty
   a_unlock_first: assert property (p_unlock_first) else $error("first unlock wrong");

   property p_chip_erase_last;
      @(posedge clk_i) disable iff (sys_rst_i)
         (state_q == H_ISSUE && op_q == OP_CHIP_ERASE && step_q == 4'h5)
            |-> cyc_data[7:0] == CMD_CHIP_ERASE;
   endproperty
   a_chip_erase_last: assert property (p_chip_erase_last) else $error("chip erase cmd wrong");

   property p_sector_addr;
      @(posedge clk_i) disable iff (sys_rst_i)
         (state_q == H_ISSUE && op_q == OP_SECTOR_ERASE && step_q == 4'h5)
            |-> cyc_addr[SECTOR_MSB:SECTOR_LSB] == addr_reg_q[SECTOR_MSB:SECTOR_LSB]
                && cyc_data[7:0] == CMD_SECTOR_ERASE;
   endproperty
   a_sector_addr: assert property (p_sector_addr) else $error("sector erase cycle wrong");

   property p_suspend_hold;
      @(posedge clk_i) disable iff (sys_rst_i)
         $rose(state_q == H_SUSP) |-> (state_q == H_SUSP)[*8];
   endproperty
   a_suspend_hold: assert property (p_suspend_hold) else $error("suspend wait too short");

   property p_resume_cmd;
      @(posedge clk_i) disable iff (sys_rst_i)
         (state_q == H_ISSUE && op_q == OP_RESUME) |-> cyc_data[7:0] == CMD_RESUME;
   endproperty
   a_resume_cmd: assert property (p_resume_cmd) else $error("resume command wrong");

endmodule // flash_host_ctrl

// >>> flash_host_ctrl_tb.sv
// Purpose: Self-checking bench for the flash host controller
// Assumes: Flash device model on the pins, word mode
// Notes:   Short suspend wait; status polled with a bound
`timescale 1ns/1ps
module flash_host_ctrl_tb
   import flash_host_pkg::*;
();
   localparam logic [15:0] ID = 16'h00A5;  // Arbitrary value
   logic        clk_i = 1'h0, sys_rst_i = 1'h1, avs_read_i = 1'h0, avs_write_i = 1'h0;
   logic [3:0]  avs_address_i = 4'h0;
   logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, st;
   logic [15:0] dq_o, dev_q;
   logic [21:0] flash_addr_o;
   logic        avs_waitrequest_o, dq_oe_o, chip_sel_n_o, write_n_o, out_en_n_o, word_mode_o;
   wire  [15:0] dq_i = dq_oe_o ? dq_o : dev_q;
   int          fails = 0, num_checks = 0, cyc = 0;
   always #20 clk_i = ~clk_i;
   flash_host_ctrl #(.SUSPEND_WAIT(8)) u_flash_host_ctrl (.clk_i, .sys_rst_i, .avs_address_i, .avs_read_i,
      .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .dq_i, .dq_o, .dq_oe_o,
      .flash_addr_o, .chip_sel_n_o, .write_n_o, .out_en_n_o, .word_mode_o);
   flash_dev_model #(.MFR_ID(ID)) u_flash_dev_model (.clk_i, .addr_i(flash_addr_o), .dq_i,
      .cs_n_i(chip_sel_n_o), .we_n_i(write_n_o), .oe_n_i(out_en_n_o), .word_i(word_mode_o), .q_o(dev_q));
   task automatic tally_and_finish;
      if (fails == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One Avalon access, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      avs_address_i   <= a;
      avs_writedata_i <= d;
      avs_write_i     <= w;
      avs_read_i      <= !w;
      do @(posedge clk_i); while (avs_waitrequest_o !== 1'h0);
      st = avs_readdata_o;
      avs_write_i <= 1'h0;
      avs_read_i  <= 1'h0;
      @(posedge clk_i);
   endtask
   task automatic op(input logic [3:0] o, input logic [21:0] a = 22'h0, input logic [15:0] d = 16'h0);
      bus(1'h1, REG_ADDR, {10'h0, a});
      bus(1'h1, REG_WDATA, {16'h0, d});
      bus(1'h1, REG_CTRL, {23'h0, 1'h1, 4'h0, o});
   endtask
   task automatic rdf(input logic [21:0] a);
      op(OP_READ, a);
      bus(1'h0, REG_STATUS, 32'h0);
   endtask
   task automatic poll(input logic [21:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
      int k = 0;
      do begin
         rdf(a);
         k++;
      end while ((st & m) !== e && k < 100);
      chk(st & m, e, nm);
   endtask
   // Cycle ceiling against a hang
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         tally_and_finish;
      end
   end
   // Main sequence
   initial begin
      repeat (4) @(posedge clk_i);
      sys_rst_i <= 1'h0;
      @(posedge clk_i);
      rdf(22'h000100);
      chk(st[15:0], 16'hFFFF, "power up");
      bus(1'h0, 4'h1, 32'h0);
      chk(st, 32'h0, "unmapped");
      chk(word_mode_o, 1'h1, "width pin");
      op(OP_PROGRAM, 22'h001234, 16'h5A3C);
      rdf(22'h001234);
      chk(st[16], 1'h1, "busy poll");
      poll(22'h001234, 32'hFFFF, 32'h5A3C, "program");
      op(OP_PROGRAM, 22'h003000, 16'h00FF);
      bus(1'h0, REG_ADDR, 32'h0);
      chk(st, 32'h00003000, "address reg");
      poll(22'h003000, 32'hFFFF, 32'h00FF, "next sector");
      op(OP_PROGRAM, 22'h001234, 16'hFFFF);
      poll(22'h001234, 32'h40000, 32'h40000, "limit flag");
      op(OP_RESET, 22'h3FFFFF);
      rdf(22'h001234);
      chk(st[15:0], 16'h5A3C, "zeros kept");
      op(OP_AUTOSELECT);
      repeat (2) begin
         rdf(22'h0);
         chk(st[15:0], ID, "ident");
      end
      op(OP_RESET);
      rdf(22'h0);
      chk(st[15:0], 16'hFFFF, "ident exit");
      op(OP_SECTOR_ERASE, 22'h001000);
      op(OP_SUSPEND);
      rdf(22'h003000);
      chk(st[15:0], 16'h00FF, "other sector");
      rdf(22'h001234);
      chk(st[15:8], 8'h00, "suspended sector");
      op(OP_RESUME);
      op(OP_RESUME);
      poll(22'h001234, 32'hFFFF, 32'hFFFF, "sector erase");
      rdf(22'h003000);
      chk(st[15:0], 16'h00FF, "sector only");
      op(OP_CHIP_ERASE);
      op(OP_SUSPEND);
      rdf(22'h003000);
      chk(st[15:8], 8'h00, "no chip suspend");
      poll(22'h003000, 32'hFFFF, 32'hFFFF, "chip erase");
      tally_and_finish;
   end
endmodule  // flash_host_ctrl_tb

// >>> flash_host_pkg.sv
// Purpose: Constants shared by the flash command host controller
// Assumes: Word-mode parallel NOR flash, 25 MHz system clock
// Notes:   Command codes and unlock addresses of the flash command set
package flash_host_pkg;

   // ------------------------------------------------------------
   // Flash command set
   // ------------------------------------------------------------
   localparam logic [21:0] UNLOCK_ADDR_1    = 22'h000555;
   localparam logic [21:0] UNLOCK_ADDR_2    = 22'h0002AA;
   localparam logic [7:0]  UNLOCK_DATA_1    = 8'hAA;
   localparam logic [7:0]  UNLOCK_DATA_2    = 8'h55;
   localparam logic [7:0]  CMD_AUTOSELECT   = 8'h90;
   localparam logic [7:0]  CMD_PROGRAM      = 8'hA0;
   localparam logic [7:0]  CMD_ERASE_SETUP  = 8'h80;
   localparam logic [7:0]  CMD_CHIP_ERASE   = 8'h10;
   localparam logic [7:0]  CMD_SECTOR_ERASE = 8'h30;
   localparam logic [7:0]  CMD_RESUME       = 8'h30;
   localparam logic [7:0]  CMD_SUSPEND      = 8'hB0;
   localparam logic [7:0]  CMD_RESET        = 8'hF0;

   // ------------------------------------------------------------
   // Sector select field and status bits
   // ------------------------------------------------------------
   localparam int SECTOR_MSB             = 20;
   localparam int SECTOR_LSB             = 12;
   localparam int TIMING_LIMIT_FLAG_BIT  = 5;
   localparam int POLLING_STATUS_BIT     = 7;
   localparam int TOGGLE_STATUS_BIT      = 6;

   // ------------------------------------------------------------
   // Host register map (byte addresses, Avalon word aligned)
   // ------------------------------------------------------------
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_ADDR   = 4'h4;
   localparam logic [3:0] REG_WDATA  = 4'h8;
   localparam logic [3:0] REG_STATUS = 4'hC;

   // Operation codes written to the control register
   localparam logic [3:0] OP_READ         = 4'h0;
   localparam logic [3:0] OP_RESET        = 4'h1;
   localparam logic [3:0] OP_AUTOSELECT   = 4'h2;
   localparam logic [3:0] OP_PROGRAM      = 4'h3;
   localparam logic [3:0] OP_CHIP_ERASE   = 4'h4;
   localparam logic [3:0] OP_SECTOR_ERASE = 4'h5;
   localparam logic [3:0] OP_SUSPEND      = 4'h6;
   localparam logic [3:0] OP_RESUME       = 4'h7;

   // ------------------------------------------------------------
   // Bus timing: cycles of 40 ns
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS     = 40;
   localparam int STROBE_TIME_NS    = 80;
   localparam int STROBE_CYCLES     = (STROBE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SUSPEND_TIME_US   = 20;
   localparam int SUSPEND_CYCLES    = (SUSPEND_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] SEQ_RESET = 4'h0;

endpackage
